// ---- bench/rail_model.sv ----
// Purpose: Rail outputs as seen by the supervisor pins
// Assumes: A rail settles within one clock of its enable
// Notes:   Faults are forced only when the bench asks
`timescale 1ns/1ps
module rail_model
  import rail_seq_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Enables and forced faults
  input wire logic [RAILS-1:0] rail_enable_in,
  input wire logic [MONS+BACKUPS-1:0] force_uv_in,
  input wire logic [MONS-1:0] force_ov_in,
  // Supervisor pins
  output logic [MONS-1:0] rail_uv_out,
  output logic [MONS-1:0] rail_ov_out,
  output logic [BACKUPS-1:0] backup_uv_out
);
  initial begin
    rail_uv_out = '1;
    rail_ov_out = '0;
    backup_uv_out = '1;
  end
  // A disabled rail sits at ground, so it reads as undervoltage
  always @(posedge clk_sys_in) begin
    rail_uv_out <= ~rail_enable_in[MONS-1:0] | force_uv_in[MONS-1:0];
    backup_uv_out <= ~rail_enable_in[6:5] | force_uv_in[6:5];
    rail_ov_out <= force_ov_in;
  end
endmodule : rail_model

// ---- bench/tb.sv ----
// Purpose: Self-checking bench of the rail strobe sequencer
// Assumes: MS_CYCLES of 20 keeps the long delays short
// Notes:   Times are taken relative to the rise of busy
`timescale 1ns/1ps
module tb;
  import rail_seq_pkg::*;
  localparam int MSC = 20;
  localparam logic [7:0] RA [6] = '{ADDR_SEQ_LO, ADDR_SEQ_HI,
    ADDR_DELAY, ADDR_INT_MASK, ADDR_ENABLE, 8'h20};
  localparam logic [32:0] RE [6] = '{{1'b0, SEQ_RST[31:0]},
    {25'h000_0000, SEQ_RST[39:32]}, 33'h0_0000_0000, 33'h0_0000_0000,
    33'h0_0000_0000, 33'h1_0000_0000};
  logic clk_sys_in = 0;
  logic rst_in = 1;
  logic psel = 0, pen = 0, pwr = 0, up_req = 0, pready, pslverr, err;
  logic dn_req = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
  logic [LS_FLAGS-1:0] ls_flt = '0, m;
  logic [6:0] fuv = '0;
  logic [MONS-1:0] fov = '0, uv, ov;
  logic [BACKUPS-1:0] buv;
  logic [RAILS-1:0] en, dis, prev_en, pe, xe, xd;
  logic [GPIOS-1:0] gpio;
  logic tight, busy, mg, mg_oe, bg, bg_oe, irq, prev_busy;
  logic [3:0] a [RAILS];
  logic [39:0] seq, seq0;
  logic [17:0] dly;
  int n_mismatch = 0, n_checks = 0, cyc = 0, t_busy = 0, t_idle = 0;
  int t_ch [RAILS];
  always #2.5 clk_sys_in = ~clk_sys_in;
  rail_strobe_sequencer #(.MS_CYCLES(MSC)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .power_up_req_in(up_req),
    .power_down_req_in(dn_req), .rail_uv_in(uv), .rail_ov_in(ov),
    .backup_uv_in(buv), .load_switch_n_fault_in(ls_flt),
    .rail_enable_out(en), .discharge_out(dis), .gpio_out(gpio),
    .supervisor_tight_out(tight), .seq_busy_out(busy),
    .main_power_good_out(mg), .main_power_good_oe_out(mg_oe),
    .backup_power_good_out(bg), .backup_power_good_oe_out(bg_oe),
    .irq_out(irq));
  rail_model far (.clk_sys_in(clk_sys_in), .rail_enable_in(en),
    .force_uv_in(fuv), .force_ov_in(fov), .rail_uv_out(uv),
    .rail_ov_out(ov), .backup_uv_out(buv));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [39:0] s, e, input string msg);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t %s seen %0h exp %0h", $time, msg, s, e);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    psel <= 1;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys_in);
    pen <= 1;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic wait_busy(input logic v, input int lim);
    int k;
    k = 0;
    while (busy !== v && k < lim) begin
      @(posedge clk_sys_in);
      k++;
    end
    check(busy, v, "busy wait");
  endtask : wait_busy
  task automatic run_end(input int lim);
    wait_busy(1, 50);
    wait_busy(0, lim);
    // One more edge so change times recorded at the last edge have landed
    @(posedge clk_sys_in);
  endtask : run_end
  function automatic int eff(input int s, input bit up,
    input logic [17:0] d);
    int t;
    t = 1;
    if (up) for (int k = 1; k < s; k++) t += (2 + d[2*k-2 +: 2]) * MSC + 2;
    else for (int k = s; k < 10; k++) t += (2 + d[2*k-2 +: 2]) * MSC * 10 + 2;
    return t;
  endfunction : eff
  // Change times recorded at every edge; hang guard
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    prev_en <= en;
    prev_busy <= busy;
    if (busy === 1'b1 && prev_busy === 1'b0) t_busy <= cyc;
    if (busy === 1'b0 && prev_busy === 1'b1) t_idle <= cyc;
    for (int i = 0; i < RAILS; i++) if (en[i] !== prev_en[i]) t_ch[i] <= cyc;
    if (cyc == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h0000_f83b));
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 0;
    repeat (6) @(posedge clk_sys_in);
    foreach (RA[i]) begin
      apb(0, RA[i], 32'h0000_0000);
      check({err, rd}, RE[i], "reset value");
    end
    apb(0, ADDR_STATUS, 32'h0000_0000);
    check(rd[3:2], 2'b11, "status good");
    apb(1, ADDR_ENABLE, 32'h0000_1FFF);
    repeat (3) @(posedge clk_sys_in);
    check({gpio, en}, 13'h1FFF, "enables");
    for (int i = 0; i < 7; i++) begin
      fuv[i] <= 1;
      repeat (10) @(posedge clk_sys_in);
      check({mg, mg_oe, bg, bg_oe}, i < 5 ? 4'h6 : 4'h9, "uv");
      fuv[i] <= 0;
      repeat (10) @(posedge clk_sys_in);
      check({mg, mg_oe, bg, bg_oe}, 4'hA, "good");
    end
    r = $urandom;
    fov <= r[4:0] | 5'h01;
    repeat (10) @(posedge clk_sys_in);
    check(mg, 1'b1, "relaxed ov");
    apb(1, ADDR_CTRL, 32'h0000_0001);
    repeat (10) @(posedge clk_sys_in);
    check({tight, mg}, 2'b10, "tight ov");
    fov <= '0;
    apb(1, ADDR_CTRL, 32'h0000_0000);
    for (int k = 0; k < LS_FLAGS; k++) begin
      r = $urandom;
      m = r[8:0];
      apb(1, ADDR_INT_MASK, {23'h00_0000, m});
      ls_flt[k] <= 1;
      repeat (8) @(posedge clk_sys_in);
      ls_flt[k] <= 0;
      repeat (8) @(posedge clk_sys_in);
      check(irq, m[k], "irq");
      apb(0, ADDR_INT_ST, 32'h0000_0000);
      check(rd, 32'h0000_0001 << k, "flag");
      apb(0, ADDR_INT_ST, 32'h0000_0000);
      check({irq, rd}, 33'h0_0000_0000, "flag clear");
    end
    // Power-up with random order, corner delays 5 ms and 2 ms
    r = $urandom;
    for (int i = 0; i < RAILS; i++) begin
      a[i] = (i == 1) ? 4'h1 : (i == 2) ? 4'hA : (i == 3) ? 4'h0 :
        4'($urandom_range(10, 0));
      seq[4*i +: 4] = a[i];
      pe[i] = r[i] & (a[i] == 4'h0);
    end
    r = $urandom;
    dly = {r[17:4], 4'h3};
    apb(1, ADDR_ENABLE, {19'h0_0000, 3'h5, pe});
    apb(1, ADDR_SEQ_LO, seq[31:0]);
    apb(1, ADDR_SEQ_HI, {24'h00_0000, seq[39:32]});
    apb(1, ADDR_DELAY, {14'h0000, dly});
    up_req <= 1;
    repeat (8) @(posedge clk_sys_in);
    up_req <= 0;
    seq0 = seq;
    apb(1, ADDR_ENABLE, 32'h0000_1FFF);
    for (int i = 0; i < 8; i++) begin
      a[i] = 4'($urandom_range(10, 0));
      seq[4*i +: 4] = a[i];
    end
    apb(1, ADDR_SEQ_LO, seq[31:0]);
    for (int i = 0; i < RAILS; i++) begin
      xe[i] = (seq0[4*i +: 4] == 4'h0) ? pe[i] : 1'b1;
    end
    run_end(2000);
    check({gpio, en, dis}, {3'h5, xe, 10'h000}, "up end");
    apb(0, ADDR_SEQ_LO, 32'h0000_0000);
    check(rd, seq[31:0], "live seq");
    for (int i = 0; i < RAILS; i++) begin
      a[i] = seq0[4*i +: 4];
      if (a[i] != 4'h0)
        check(t_ch[i] - t_busy, eff(a[i], 1, dly), "up time");
      xd[i] = (seq[4*i +: 4] != 4'h0);
    end
    // Stretched power-down, then power-up from the control register
    apb(1, ADDR_CTRL, 32'h0000_000A);
    run_end(12000);
    check(t_idle - t_busy, PD_TOTAL_MS * MSC + 2, "down hold");
    check({en, dis}, {xe & ~xd, xd}, "down end");
    for (int i = 0; i < RAILS; i++) begin
      a[i] = seq[4*i +: 4];
      if (xd[i] & xe[i])
        check(t_ch[i] - t_busy, eff(a[i], 0, dly), "dn time");
    end
    apb(1, ADDR_CTRL, 32'h0000_0004);
    // Pin request while busy must be ignored
    dn_req <= 1;
    run_end(2000);
    check({en, dis}, {xe | xd, 10'h000}, "reup end");
    wrap_up();
  end
endmodule : tb

// ---- shared/rail_seq_pkg.sv ----
// Purpose: Constants and types of the rail strobe sequencer
// Assumes: 200 MHz system clock, APB register access
// Notes:   Byte addresses are word aligned
package rail_seq_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int RAILS = 10;
  localparam int GPIOS = 3;
  localparam int MONS = 5;
  localparam int BACKUPS = 2;
  localparam int LS_FLAGS = 9;
  localparam int ENW = RAILS + GPIOS;
  localparam int PINS = 2 + MONS + MONS + BACKUPS + LS_FLAGS;
  localparam logic [3:0] STROBES = 4'hA;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_SEQ_LO = 8'h0C;
  localparam logic [7:0] ADDR_SEQ_HI = 8'h10;
  localparam logic [7:0] ADDR_DELAY = 8'h14;
  localparam logic [7:0] ADDR_INT_ST = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
  localparam int CTRL_STRICT = 0;
  localparam int CTRL_STRETCH = 1;
  localparam int CTRL_UP = 2;
  localparam int CTRL_DOWN = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [39:0] SEQ_RST = 40'hA9_8217_6355;
  localparam logic [17:0] DLY_RST = 18'h0_0000;
  localparam logic [12:0] EN_RST = 13'h0000;
  localparam logic [8:0] MASK_RST = 9'h000;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam logic [5:0] DLY_MIN_MS = 6'h02;
  localparam logic [5:0] DLY_MAX_MS = 6'h05;
  localparam logic [5:0] PD_STRETCH = 6'h0A;
  localparam logic [8:0] PD_TOTAL_MS = 9'h1F4;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_STROBE = 4'b0010,
    S_WAIT = 4'b0100,
    S_HOLD = 4'b1000
  } seq_state_t;
endpackage : rail_seq_pkg

// ---- src/ms_tick.sv ----
// Purpose: Millisecond enable pulse from the system clock
// Assumes: Clear restarts a full period
// Notes:   Pulse comes exactly MS_CYCLES cycles after a clear
`timescale 1ns/1ps
module ms_tick #(
  parameter int MS_CYCLES = 200000
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  output logic tick_out
);
  localparam int CW = $clog2(MS_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(MS_CYCLES - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tick_t;
  tick_t r_q, r_d;

  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("ms_tick needs MS_CYCLES of at least two");
  end

  always_comb begin
    r_d = r_q;
    r_d.tick = 1'b0;
    if (clear_in) begin
      r_d.cnt = '0;
    end else if (r_q.cnt == LAST) begin
      r_d.cnt = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign tick_out = r_q.tick;
endmodule : ms_tick

// ---- src/pin_filter.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_sys_in
// Notes:   Output rises only when stages two and three agree, falls once they differ
`timescale 1ns/1ps
module pin_filter #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } filt_t;
  filt_t r_q, r_d;

  if (W < 1) begin : g_bad_w
    $error("pin_filter needs W of at least one");
  end

  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    // Bitwise agreement of the two settled stages
    r_d.o = (r_q.o & ~(r_q.s2 ^ r_q.s3)) | (r_q.s3 & ~(r_q.s2 ^ r_q.s3));
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign level_out = r_q.o;
endmodule : pin_filter

// ---- src/rail_strobe_sequencer.sv ----
// Purpose: Rail strobe sequencer, supervisor and load switch flags
// Assumes: APB slave, 200 MHz clock, pins pass a three-stage filter
// Notes:   Rails 0-3 main bucks, 4 linear, 5-6 backup, 7-9 switches
`timescale 1ns/1ps
// What this block does
// [R1] Ten strobes separated by nine delays, stepped through in order
// [R2] Each rail enables when its assigned strobe fires
// [R3] One strobe per rail; rails sharing a strobe switch together
// [R4] Each delay selectable from 2 ms to 5 ms
// [R5] Default order at reset; software may rewrite assignments and delays
// [R6] Software sets or clears every rail, switch and GPIO enable
// [R7] Relaxed supervisor checks undervoltage only
// [R8] Tight supervisor flags under- and overvoltage with narrow windows
// [R9] Four main bucks and linear regulator combine into main good
// [R10] Two backup bucks report on a separate good output
// [R11] Switch overtemperature, overcurrent, undervoltage raise readable flags
// [R12] Power-up fires strobe one at once, then delays and strobes
// [R13] Rails with assignment zero are left untouched by sequences
// [R14] Power-down runs strobes ten to one, disabling and discharging
// [R15] Power-down delays stretch tenfold; final state 500 ms later
// [R16] Delays counted in millisecond ticks; index steps only on expiry
// [R17] Writes during a running sequence do not disturb it, except the CTRL stretch bit, which later power-down delays read live
module rail_strobe_sequencer
  import rail_seq_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Sequence triggers
  input wire logic power_up_req_in,
  input wire logic power_down_req_in,
  // Supervisor pins
  input wire logic [MONS-1:0] rail_uv_in,
  input wire logic [MONS-1:0] rail_ov_in,
  input wire logic [BACKUPS-1:0] backup_uv_in,
  input wire logic [LS_FLAGS-1:0] load_switch_n_fault_in,
  // Rail control
  output logic [RAILS-1:0] rail_enable_out,
  output logic [RAILS-1:0] discharge_out,
  output logic [GPIOS-1:0] gpio_out,
  output logic supervisor_tight_out,
  output logic seq_busy_out,
  // Power good and interrupt
  output logic main_power_good_out,
  output logic main_power_good_oe_out,
  output logic backup_power_good_out,
  output logic backup_power_good_oe_out,
  output logic irq_out
);
  typedef struct packed {
    seq_state_t st;
    logic [3:0] idx;
    logic up;
    logic [5:0] dly;
    logic [8:0] pd_ms;
    logic [39:0] seq;
    logic [17:0] dly_cfg;
    logic [39:0] seq_snap;
    logic [17:0] dly_snap;
    logic [ENW-1:0] en;
    logic [RAILS-1:0] dis;
    logic strict;
    logic stretch;
    logic [1:0] trig_prev;
    logic [LS_FLAGS-1:0] ls_prev;
    logic [LS_FLAGS-1:0] irq_st;
    logic [LS_FLAGS-1:0] irq_mask;
    logic main_pg;
    logic backup_pg;
    logic [31:0] rdata;
  } regs_t;
  regs_t r_q, r_d;

  logic [PINS-1:0] filt;
  logic dly_tick, pd_tick, clr_dly, clr_pd;
  logic [RAILS-1:0] hit, unassigned;
  logic acc, wr, rd, mapped, busy, up_go, dn_go;
  logic [MONS-1:0] uv, ov;
  logic [BACKUPS-1:0] bu_uv;
  logic [LS_FLAGS-1:0] ls_f, ls_rise;

  // ---------------------------------------------------------------
  // Pin synchronisers and millisecond enables
  // ---------------------------------------------------------------
  pin_filter #(.W(PINS)) u_pins (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in({load_switch_n_fault_in, backup_uv_in, rail_ov_in,
             rail_uv_in, power_down_req_in, power_up_req_in}),
    .level_out(filt)
  );
  // Separate pd timer so delay restarts do not skew the 500 ms hold
  ms_tick #(.MS_CYCLES(MS_CYCLES)) u_dly_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clear_in(clr_dly),
    .tick_out(dly_tick)
  );
  ms_tick #(.MS_CYCLES(MS_CYCLES)) u_pd_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clear_in(clr_pd),
    .tick_out(pd_tick)
  );
  assign uv = filt[2+:MONS];
  assign ov = filt[2+MONS+:MONS];
  assign bu_uv = filt[2+2*MONS+:BACKUPS];
  assign ls_f = filt[2+2*MONS+BACKUPS+:LS_FLAGS];

  // ---------------------------------------------------------------
  // Strobe match per rail
  // ---------------------------------------------------------------
  for (genvar i = 0; i < RAILS; i++) begin : g_rail
    // Index never zero while busy, so unassigned rails never match a strobe
    assign hit[i] = (r_q.seq_snap[4*i+:4] == r_q.idx); // [R2] [R3] [R13]
    assign unassigned[i] = (r_q.seq_snap[4*i+:4] == 4'h0);
  end

  // ---------------------------------------------------------------
  // Bus decode and triggers
  // ---------------------------------------------------------------
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign rd = acc & ~pwrite_in;
  assign busy = (r_q.st != S_IDLE);
  assign ls_rise = ls_f & ~r_q.ls_prev;
  always_comb begin
    case (paddr_in)
      ADDR_CTRL, ADDR_STATUS, ADDR_ENABLE, ADDR_SEQ_LO,
      ADDR_SEQ_HI, ADDR_DELAY, ADDR_INT_ST, ADDR_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign up_go = (filt[0] & ~r_q.trig_prev[0])
    | (wr & (paddr_in == ADDR_CTRL) & pwdata_in[CTRL_UP]);
  assign dn_go = (filt[1] & ~r_q.trig_prev[1])
    | (wr & (paddr_in == ADDR_CTRL) & pwdata_in[CTRL_DOWN]);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] dsel;
    logic [1:0] code;
    logic [5:0] base;
    dsel = 4'h0;
    code = 2'h0;
    base = 6'h00;
    r_d = r_q;
    clr_dly = 1'b0;
    clr_pd = 1'b0;
    r_d.trig_prev = filt[1:0];
    r_d.ls_prev = ls_f;
    // Read data captured in setup so prdata comes from a flop
    if (psel_in & ~penable_in) begin
      case (paddr_in)
        ADDR_CTRL: r_d.rdata = {30'h0000_0000, r_q.stretch, r_q.strict};
        ADDR_STATUS: r_d.rdata = {28'h000_0000, r_q.backup_pg,
                                  r_q.main_pg, r_q.up, busy};
        ADDR_ENABLE: r_d.rdata = {19'h0_0000, r_q.en};
        ADDR_SEQ_LO: r_d.rdata = r_q.seq[31:0];
        ADDR_SEQ_HI: r_d.rdata = {24'h00_0000, r_q.seq[39:32]};
        ADDR_DELAY: r_d.rdata = {14'h0000, r_q.dly_cfg};
        ADDR_INT_ST: r_d.rdata = {23'h00_0000, r_q.irq_st}; // [R11]
        ADDR_INT_MASK: r_d.rdata = {23'h00_0000, r_q.irq_mask};
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (paddr_in)
        ADDR_CTRL: begin
          r_d.strict = pwdata_in[CTRL_STRICT];
          r_d.stretch = pwdata_in[CTRL_STRETCH];
        end
        ADDR_ENABLE: begin
          // Enables locked while the sequencer owns the rails
          if (!busy) begin
            r_d.en = pwdata_in[ENW-1:0]; // [R6]
            r_d.dis = r_q.dis & ~pwdata_in[RAILS-1:0];
          end
        end
        // Only the live copy changes; the running snapshot stays put
        ADDR_SEQ_LO: r_d.seq[31:0] = pwdata_in; // [R5] [R17]
        ADDR_SEQ_HI: r_d.seq[39:32] = pwdata_in[7:0]; // [R5]
        ADDR_DELAY: r_d.dly_cfg = pwdata_in[17:0]; // [R5] [R17]
        ADDR_INT_MASK: r_d.irq_mask = pwdata_in[LS_FLAGS-1:0];
        default: r_d.strict = r_q.strict;
      endcase
    end
    // Read clears only what setup captured, so no event is lost
    if (rd & (paddr_in == ADDR_INT_ST)) begin
      r_d.irq_st = r_q.irq_st & ~r_q.rdata[LS_FLAGS-1:0];
    end
    r_d.irq_st = r_d.irq_st | ls_rise; // [R11]
    // Sequencer
    case (r_q.st)
      S_IDLE: begin
        if (up_go | dn_go) begin
          r_d.seq_snap = r_q.seq; // [R17]
          r_d.dly_snap = r_q.dly_cfg; // [R17]
          r_d.up = up_go;
          r_d.st = S_STROBE;
          r_d.pd_ms = 9'h000;
          clr_pd = 1'b1;
          // Up starts at one, down at ten
          r_d.idx = up_go ? 4'h1 : STROBES; // [R12] [R14]
        end
      end
      S_STROBE: begin
        if (r_q.up) begin
          r_d.en[RAILS-1:0] = r_q.en[RAILS-1:0] | hit; // [R2] [R3]
          r_d.dis = r_q.dis & ~hit;
        end else begin
          r_d.en[RAILS-1:0] = r_q.en[RAILS-1:0] & ~hit; // [R14]
          r_d.dis = r_q.dis | hit; // [R14]
        end
        if (r_q.up && (r_q.idx == STROBES)) begin
          r_d.st = S_IDLE; // [R1]
        end else if (!r_q.up && (r_q.idx == 4'h1)) begin
          r_d.st = S_HOLD;
        end else begin
          // Delay after strobe k going up is k, going down k-1
          dsel = r_q.up ? r_q.idx : r_q.idx - 4'h1;
          code = r_q.dly_snap[{dsel - 4'h1, 1'b0}+:2];
          base = DLY_MIN_MS + {4'h0, code}; // [R4]
          r_d.dly = r_q.stretch & !r_q.up ?
            6'(base * PD_STRETCH) : base; // [R15]
          clr_dly = 1'b1;
          r_d.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (dly_tick) begin
          if (r_q.dly == 6'h01) begin
            r_d.idx = r_q.up ? r_q.idx + 4'h1 : r_q.idx - 4'h1; // [R16]
            r_d.st = S_STROBE; // [R1] [R12]
          end else begin
            r_d.dly = r_q.dly - 6'h01; // [R16]
          end
        end
      end
      S_HOLD: begin
        if (r_q.pd_ms == PD_TOTAL_MS) begin
          r_d.st = S_IDLE; // [R15]
        end
      end
      default: r_d.st = S_IDLE;
    endcase
    if (busy && !r_q.up && pd_tick && (r_q.pd_ms != PD_TOTAL_MS)) begin
      r_d.pd_ms = r_q.pd_ms + 9'h001; // [R15]
    end
    // Supervisor; strict also adds overvoltage
    r_d.main_pg = ~|(r_q.en[MONS-1:0]
      & (uv | (ov & {MONS{r_q.strict}}))); // [R7] [R8] [R9]
    r_d.backup_pg = ~|(r_q.en[MONS+:BACKUPS] & bu_uv); // [R10]
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_q <= '0;
      r_q.st <= S_IDLE;
      r_q.seq <= SEQ_RST; // [R5]
      r_q.dly_cfg <= DLY_RST;
      r_q.en <= EN_RST;
      r_q.irq_mask <= MASK_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_out = r_q.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign rail_enable_out = r_q.en[RAILS-1:0];
  assign gpio_out = r_q.en[ENW-1:RAILS];
  assign discharge_out = r_q.dis;
  // Analog threshold select for narrow windows
  assign supervisor_tight_out = r_q.strict; // [R8]
  assign seq_busy_out = busy;
  assign main_power_good_out = r_q.main_pg;
  assign main_power_good_oe_out = ~r_q.main_pg;
  assign backup_power_good_out = r_q.backup_pg;
  assign backup_power_good_oe_out = ~r_q.backup_pg;
  assign irq_out = |(r_q.irq_st & r_q.irq_mask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  strobe_range_a: assert property ( // [R1]
    @(posedge clk_sys_in) disable iff (rst_in)
    busy |-> (r_q.idx >= 4'h1) && (r_q.idx <= STROBES))
    else $error("Strobe index out of range");
  up_enable_a: assert property ( // [R2]
    @(posedge clk_sys_in) disable iff (rst_in)
    (r_q.st == S_STROBE) && r_q.up
    |=> ((r_q.en[RAILS-1:0] & $past(hit)) == $past(hit)))
    else $error("Assigned rail not enabled at its strobe");
  delay_range_a: assert property ( // [R4]
    @(posedge clk_sys_in) disable iff (rst_in)
    (r_q.st == S_STROBE) ##1 (r_q.st == S_WAIT) |->
    (r_q.dly >= DLY_MIN_MS) && (!r_q.up || r_q.dly <= DLY_MAX_MS))
    else $error("Delay load outside range");
  enable_write_a: assert property ( // [R6]
    @(posedge clk_sys_in) disable iff (rst_in)
    wr && (paddr_in == ADDR_ENABLE) && !busy
    |=> r_q.en == $past(pwdata_in[ENW-1:0]))
    else $error("Enable write lost");
  relaxed_a: assert property ( // [R7]
    @(posedge clk_sys_in) disable iff (rst_in)
    !r_q.strict && !(|(r_q.en[MONS-1:0] & uv)) |=> r_q.main_pg)
    else $error("Relaxed mode reacted to overvoltage");
  strict_a: assert property ( // [R8]
    @(posedge clk_sys_in) disable iff (rst_in)
    r_q.strict && |(r_q.en[MONS-1:0] & ov) |=> !main_power_good_out)
    else $error("Strict mode missed overvoltage");
  backup_pg_a: assert property ( // [R10]
    @(posedge clk_sys_in) disable iff (rst_in)
    |(r_q.en[MONS+:BACKUPS] & bu_uv) |=> !backup_power_good_out)
    else $error("Backup fault not reported");
  ls_flag_a: assert property ( // [R11]
    @(posedge clk_sys_in) disable iff (rst_in)
    |ls_rise |=> ((r_q.irq_st & $past(ls_rise)) == $past(ls_rise)))
    else $error("Switch event flag lost");
  first_strobe_a: assert property ( // [R12]
    @(posedge clk_sys_in) disable iff (rst_in)
    !busy && up_go |=> (r_q.st == S_STROBE) && (r_q.idx == 4'h1))
    else $error("Power-up did not start at strobe one");
  unassigned_a: assert property ( // [R13]
    @(posedge clk_sys_in) disable iff (rst_in)
    busy |=> ((r_q.en[RAILS-1:0] ^ $past(r_q.en[RAILS-1:0]))
              & $past(unassigned)) == '0)
    else $error("Unassigned rail changed");
  down_strobe_a: assert property ( // [R14]
    @(posedge clk_sys_in) disable iff (rst_in)
    (r_q.st == S_STROBE) && !r_q.up |=>
    ((r_q.en[RAILS-1:0] & $past(hit)) == '0)
    && ((r_q.dis & $past(hit)) == $past(hit)))
    else $error("Power-down strobe did not disable");
  hold_time_a: assert property ( // [R15]
    @(posedge clk_sys_in) disable iff (rst_in)
    (r_q.st == S_HOLD) ##1 (r_q.st == S_IDLE)
    |-> $past(r_q.pd_ms) == PD_TOTAL_MS)
    else $error("Power-down ended before 500 ms");
  advance_gate_a: assert property ( // [R16]
    @(posedge clk_sys_in) disable iff (rst_in)
    (r_q.st == S_WAIT) && !(dly_tick && r_q.dly == 6'h01)
    |=> $stable(r_q.idx))
    else $error("Index moved before delay expiry");
  snapshot_a: assert property ( // [R17]
    @(posedge clk_sys_in) disable iff (rst_in)
    busy ##1 busy |-> $stable(r_q.seq_snap) && $stable(r_q.dly_snap))
    else $error("Running sequence disturbed");
endmodule : rail_strobe_sequencer
